// ==== logic/adcsq_conv.v ====
`timescale 1ns/1ns
`default_nettype none
`include "adcsq_defines.vh"
// stand-in conversion engine: fixed latency, samples the analog word
module adcsq_conv #(
  parameter CONV_CYC = `ADCSQ_CONV_CYC
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // request
  input wire start,
  input wire abort,
  input wire [11:0] sample,
  // result
  output reg done,
  output reg [11:0] result
);
  reg [7:0] cnt_q;
  reg busy_q;
  // counts down one conversion; abort drops it
  always @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= 8'h00;
      busy_q <= 1'b0;
      done <= 1'b0;
      result <= 12'h000;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy_q <= 1'b0;
      end else if (start) begin
        busy_q <= 1'b1;
        cnt_q <= CONV_CYC[7:0] - 8'h01;
      end else if (busy_q) begin
        if (cnt_q == 8'h00) begin
          busy_q <= 1'b0;
          done <= 1'b1;
          result <= sample;
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== logic/adcsq_defines.vh ====
`ifndef ADCSQ_DEFINES_VH
`define ADCSQ_DEFINES_VH
// register byte addresses (word aligned)
`define ADCSQ_ADDR_CTRL 8'h00
`define ADCSQ_ADDR_CFG 8'h04
`define ADCSQ_ADDR_STAT 8'h08
`define ADCSQ_ADDR_DATA0 8'h40
`define ADCSQ_ADDR_XFER 8'h80
// control register fields
`define ADCSQ_CTRL_FIRST_LSB 0
`define ADCSQ_CTRL_LAST_LSB 4
`define ADCSQ_CTRL_REPEAT_BIT 8
// configuration register fields
`define ADCSQ_CFG_EXT_BIT 0
// status register fields
`define ADCSQ_STAT_READY_BIT 0
`define ADCSQ_STAT_BUSY_BIT 1
// channel layout
`define ADCSQ_NUM_CH 9
`define ADCSQ_TEMP_CH 4'h8
// ready pulse timing
`define ADCSQ_CLK_MHZ 100
`define ADCSQ_PULSE_US 2
`define ADCSQ_PULSE_CYC (`ADCSQ_PULSE_US * `ADCSQ_CLK_MHZ)
// conversion time per single conversion
`define ADCSQ_CONV_CYC 16
`endif

// ==== logic/adcsq_edge.v ====
`timescale 1ns/1ns
`default_nettype none
// synchroniser and rising edge detector for the external start strobe
module adcsq_edge (
  // clock and reset
  input wire clk,
  input wire rstn,
  // strobe
  input wire pin_in,
  output reg rise
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  // first stage feeds only the second
  always @(posedge clk) begin
    if (!rstn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      rise <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      rise <= s2_q & ~s3_q;
    end
  end
endmodule
`default_nettype wire

// ==== logic/adcsq_top.v ====
`timescale 1ns/1ns
`default_nettype none
`include "adcsq_defines.vh"
module adcsq_top #(
  parameter NUM_CH = `ADCSQ_NUM_CH,
  parameter CONV_CYC = `ADCSQ_CONV_CYC
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // trigger and serial readout gate
  input wire conv_start_pin,
  input wire chip_select_n,
  input wire serial_clk,
  // analog front end stand-in
  input wire [11:0] analog_sample,
  output reg [3:0] mux_channel,
  output reg temp_high_current,
  // host handshake
  output reg result_ready_pin_n
);
  // scan states
  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_WAIT = 2'h2;
  localparam ST_PUSH = 2'h3;

  // register, scan and buffer state
  reg [1:0] state_q;
  reg [3:0] first_q;
  reg [3:0] last_q;
  reg repeat_q;
  reg ext_en_q;
  reg ready_flag_q;
  reg auto_run_q;
  reg [3:0] chan_q;
  reg temp_phase_q;
  reg [11:0] temp_high_q;
  reg [11:0] hold_q [0:NUM_CH-1];
  reg [11:0] data_q [0:NUM_CH-1];
  reg [NUM_CH-1:0] pend_q;
  reg [NUM_CH-1:0] busy_reg_q;
  reg [3:0] xfer_idx_q;
  reg sclk_q;
  reg [7:0] pulse_cnt_q;
  reg conv_start_q;
  reg ready_defer_q;

  wire ext_rise;
  wire conv_done;
  wire [11:0] conv_result;

  // bus decode: a request is taken only while ack is low, so just once
  wire acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = acc & wb_we_i & wb_sel_i[0];
  wire wr_ctrl = wr & (wb_adr_i == `ADCSQ_ADDR_CTRL);
  wire wr_cfg = wr & (wb_adr_i == `ADCSQ_ADDR_CFG);
  wire wr_xfer = wr & (wb_adr_i == `ADCSQ_ADDR_XFER);
  // nine data words from the data base address, one per channel
  wire rd_data = acc & ~wb_we_i & (wb_adr_i >= `ADCSQ_ADDR_DATA0) &
    (wb_adr_i < `ADCSQ_ADDR_DATA0 + 8'h24);
  wire [3:0] rd_idx = wb_adr_i[5:2];

  // internal start comes only from control writes in internal mode
  wire int_trig = wr_ctrl & ~ext_en_q;
  wire ext_trig = ext_en_q & ext_rise;
  wire restart = int_trig | ext_trig;
  // auto mode only in internal trigger mode with repeat set
  wire auto_sel = ~ext_en_q & repeat_q;
  // events that end auto rescans at the next group boundary
  wire new_cfg = wr_cfg & wb_dat_i[`ADCSQ_CFG_EXT_BIT];
  wire new_direct = wr_ctrl & ~wb_dat_i[`ADCSQ_CTRL_REPEAT_BIT];
  // the temperature channel finishes only after its low current pass
  wire last_done = conv_done & (chan_q == last_q) &
    ~((chan_q == `ADCSQ_TEMP_CH) & ~temp_phase_q);
  // serial edge is gated by chip select
  wire sclk_rise = serial_clk & ~sclk_q & ~chip_select_n;

  // the strobe is asynchronous; only its synchronised edge is acted on
  adcsq_edge u_edge (
    .clk(clk),
    .rstn(rstn),
    .pin_in(conv_start_pin),
    .rise(ext_rise)
  );

  // a restart aborts the conversion in flight so no stale result lands
  adcsq_conv #(
    .CONV_CYC(CONV_CYC)
  ) u_conv (
    .clk(clk),
    .rstn(rstn),
    .start(conv_start_q),
    .abort(restart),
    .sample(analog_sample),
    .done(conv_done),
    .result(conv_result)
  );

  // configuration and control registers
  always @(posedge clk) begin
    if (!rstn) begin
      first_q <= 4'h0;
      last_q <= 4'h0;
      repeat_q <= 1'b0;
      ext_en_q <= 1'b0;
    end else begin
      // control writes always land, even where they start nothing
      if (wr_ctrl) begin
        first_q <= wb_dat_i[`ADCSQ_CTRL_FIRST_LSB +: 4];
        last_q <= wb_dat_i[`ADCSQ_CTRL_LAST_LSB +: 4];
        repeat_q <= wb_dat_i[`ADCSQ_CTRL_REPEAT_BIT];
      end
      if (wr_cfg) begin
        ext_en_q <= wb_dat_i[`ADCSQ_CFG_EXT_BIT];
      end
    end
  end

  // scan sequencer; scan order undefined if last is below first
  always @(posedge clk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      chan_q <= 4'h0;
      temp_phase_q <= 1'b0;
      temp_high_q <= 12'h000;
      auto_run_q <= 1'b0;
      conv_start_q <= 1'b0;
      mux_channel <= 4'h0;
      temp_high_current <= 1'b0;
    end else begin
      conv_start_q <= 1'b0;
      if (restart) begin
        // restart abandons any scan in progress
        state_q <= ST_CONV;
        chan_q <= first_q;
        if (int_trig) begin
          chan_q <= wb_dat_i[`ADCSQ_CTRL_FIRST_LSB +: 4];
        end
        temp_phase_q <= 1'b0;
        auto_run_q <= int_trig & wb_dat_i[`ADCSQ_CTRL_REPEAT_BIT];
      end else begin
        if (new_cfg | new_direct) begin
          auto_run_q <= 1'b0;
        end
        case (state_q)
          ST_CONV: begin
            // the mux moves first; the engine takes the start a cycle later
            mux_channel <= chan_q;
            temp_high_current <= (chan_q == `ADCSQ_TEMP_CH) & ~temp_phase_q;
            conv_start_q <= 1'b1;
            state_q <= ST_WAIT;
          end
          ST_WAIT: begin
            if (conv_done) begin
              if ((chan_q == `ADCSQ_TEMP_CH) & ~temp_phase_q) begin
                // first of two temperature conversions at high current
                temp_high_q <= conv_result;
                temp_phase_q <= 1'b1;
                state_q <= ST_CONV;
              end else if (last_done) begin
                temp_phase_q <= 1'b0;
                state_q <= ST_PUSH;
              end else begin
                temp_phase_q <= 1'b0;
                chan_q <= chan_q + 4'h1;
                state_q <= ST_CONV;
              end
            end
          end
          ST_PUSH: begin
            // direct scans stop; auto scans wrap to the first channel
            if (auto_run_q & auto_sel & ~new_cfg & ~new_direct) begin
              chan_q <= first_q;
              state_q <= ST_CONV;
            end else begin
              state_q <= ST_IDLE;
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // holding, data and readout interlock per channel
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
      // the temperature result is final only after its second pass
      wire hit = (state_q == ST_WAIT) & conv_done & (chan_q == g) &
        ~((g == NUM_CH - 1) & ~temp_phase_q);
      wire [11:0] res = (g == NUM_CH - 1) ?
        (temp_high_q - conv_result) : conv_result;
      // a push is held back while this word sits in the shift register
      wire push = (state_q == ST_PUSH) & ~restart;
      always @(posedge clk) begin
        if (!rstn) begin
          hold_q[g] <= 12'h000;
          data_q[g] <= 12'h000;
          pend_q[g] <= 1'b0;
        end else begin
          if (hit) begin
            hold_q[g] <= res;
          end
          // a deferred copy takes the holding word as it stands at frame end
          if ((push | pend_q[g]) & ~busy_reg_q[g]) begin
            data_q[g] <= hold_q[g];
            pend_q[g] <= 1'b0;
          end else if (push) begin
            pend_q[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // serial readout window: the shift load marks one data register busy
  always @(posedge clk) begin
    if (!rstn) begin
      busy_reg_q <= {NUM_CH{1'b0}};
      xfer_idx_q <= 4'h0;
      sclk_q <= 1'b0;
    end else begin
      // last serial clock level, for its rising edge
      sclk_q <= serial_clk;
      if (wr_xfer) begin
        xfer_idx_q <= wb_dat_i[3:0];
      end
      // busy while selected and a serial edge has begun the shift
      if (chip_select_n) begin
        busy_reg_q <= {NUM_CH{1'b0}};
      end else if (sclk_rise & (xfer_idx_q < NUM_CH)) begin
        busy_reg_q[xfer_idx_q] <= 1'b1;
      end
    end
  end

  // ready flag and ready pin
  // a group push that no restart overrides
  wire update_all = (state_q == ST_PUSH) & ~restart;
  // a direct group with a word held back by the serial frame signals only
  // once that word has been copied, so the host never reads stale data
  wire set_direct = update_all & ~auto_run_q & ~(|busy_reg_q);
  wire defer_done = ready_defer_q & ~(|pend_q);
  // the pin is released as the count reaches one: a full pulse low
  wire [31:0] pulse_load = `ADCSQ_PULSE_CYC;
  // auto pulses restart on every update: a group shorter than the pulse
  // keeps the pin low throughout
  always @(posedge clk) begin
    if (!rstn) begin
      ready_flag_q <= 1'b0;
      result_ready_pin_n <= 1'b1;
      pulse_cnt_q <= 8'h00;
      ready_defer_q <= 1'b0;
    end else begin
      // remember a direct push whose copy waits for the frame to end
      if (restart | defer_done) begin
        ready_defer_q <= 1'b0;
      end else if (update_all & ~auto_run_q & (|busy_reg_q)) begin
        ready_defer_q <= 1'b1;
      end
      if (set_direct | defer_done) begin
        // set wins over a coincident read clear
        ready_flag_q <= 1'b1;
        result_ready_pin_n <= 1'b0;
      end else if (rd_data | restart) begin
        ready_flag_q <= 1'b0;
        result_ready_pin_n <= 1'b1;
        pulse_cnt_q <= 8'h00;
      end else if (update_all & auto_run_q) begin
        ready_flag_q <= 1'b0;
        result_ready_pin_n <= 1'b0;
        pulse_cnt_q <= pulse_load[7:0];
      end else if (auto_run_q | (pulse_cnt_q != 8'h00)) begin
        ready_flag_q <= 1'b0;
        if (pulse_cnt_q == 8'h01) begin
          result_ready_pin_n <= 1'b1;
        end
        if (pulse_cnt_q != 8'h00) begin
          pulse_cnt_q <= pulse_cnt_q - 8'h01;
        end
      end
    end
  end

  // wishbone answer: ack one cycle after request, dropped the next
  always @(posedge clk) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      // unmapped reads return zero; writes there are acked and dropped
      wb_ack_o <= acc;
      wb_dat_o <= 32'h00000000;
      if (acc & ~wb_we_i) begin
        if (wb_adr_i == `ADCSQ_ADDR_CTRL) begin
          wb_dat_o <= {23'h000000, repeat_q, last_q, first_q};
        end else if (wb_adr_i == `ADCSQ_ADDR_CFG) begin
          wb_dat_o <= {31'h00000000, ext_en_q};
        end else if (wb_adr_i == `ADCSQ_ADDR_STAT) begin
          wb_dat_o <= {30'h00000000, state_q != ST_IDLE, ready_flag_q};
        end else if (rd_data) begin
          wb_dat_o <= {20'h00000, data_q[rd_idx]};
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/adcsq_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module adcsq_host (
  // clock
  input wire logic clk,
  // bench asks for an open readout frame
  input wire logic hold_frame,
  // serial side
  output logic chip_select_n,
  output logic serial_clk
);
  logic [1:0] div_q;
  initial begin
    chip_select_n = 1'b1;
    serial_clk = 1'b0;
    div_q = 2'h0;
  end
  // select stays high unless asked, so conversions stay quiet
  always @(posedge clk) begin
    chip_select_n <= !hold_frame;
    div_q <= hold_frame ? div_q + 2'h1 : 2'h0;
    serial_clk <= hold_frame && div_q[1]; // stands still outside frames
  end
endmodule
`default_nettype wire

// ==== tb/adcsq_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
module adcsq_sva (
  // clock, reset
  input wire logic clk,
  input wire logic rstn,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // converter and handshake
  input wire logic [3:0] mux_channel,
  input wire logic temp_high_current,
  input wire logic result_ready_pin_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // reads of the nine data words, at the edge the design takes them
  wire logic rd_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
    && wb_adr_i >= 8'h40 && wb_adr_i <= 8'h60;
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_low2;
    !result_ready_pin_n [*2];
  endsequence
  property p_ack_next;
    s_req |=> wb_ack_o;
  endproperty
  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_ack_cause;
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
  endproperty
  property p_unmapped;
    wb_ack_o && !wb_we_i && wb_adr_i == 8'hC0 |-> wb_dat_o == 32'h0;
  endproperty
  property p_rd_clear;
    rd_req && !result_ready_pin_n |=> result_ready_pin_n;
  endproperty
  property p_temp;
    temp_high_current |-> mux_channel == 4'h8;
  endproperty
  property p_range;
    mux_channel <= 4'h8;
  endproperty
  // a low pulse never lasts a single cycle unless a bus cycle cut it
  property p_pulse;
    $fell(result_ready_pin_n) && !wb_cyc_i |-> s_low2;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("ack missing");
  a_ack_once: assert property (p_ack_once)
    else $error("ack too long");
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_rd_clear: assert property (p_rd_clear)
    else $error("ready pin kept after read");
  a_temp: assert property (p_temp)
    else $error("high current off channel eight");
  a_range: assert property (p_range)
    else $error("channel out of range");
  a_pulse: assert property (p_pulse)
    else $error("ready pulse too short");
endmodule
`default_nettype wire

// ==== tb/adcsq_top_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module adcsq_top_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic conv = 1'b0;
  logic hold = 1'b0;
  logic ok = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, rd;
  logic [11:0] smp = 12'h000;
  logic [3:0] mux;
  logic ack, thi, rdy_n, cs_n, sclk;
  logic [7:0] grp [3] = '{8'h42, 8'h80, 8'h88};
  integer n_fail = 0;
  integer n_checks = 0;
  integer seed = 32'h1AC0;
  integer val [0:9];
  integer exp_d [0:8];
  integer i, n;
  adcsq_top #(.CONV_CYC(120)) uut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .conv_start_pin(conv), .chip_select_n(cs_n), .serial_clk(sclk),
    .analog_sample(smp), .mux_channel(mux), .temp_high_current(thi),
    .result_ready_pin_n(rdy_n));
  adcsq_host host (.clk(clk), .hold_frame(hold), .chip_select_n(cs_n),
    .serial_clk(sclk));
  always #5 clk = ~clk;
  // front end stand-in; low diode current reads the tenth word
  always @(posedge clk)
    smp <= (mux == 4'h8 && !thi) ? val[9][11:0] : val[mux][11:0];
  task chk(input logic [31:0] s, input logic [31:0] w);
    n_checks++;
    if (s !== w) begin
      n_fail++;
      $display("[ERR] %0t seen %h want %h", $time, s, w);
    end
  endtask
  // one classic cycle; request stands until ack is seen
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    if (k >= 50) n_fail++;
  endtask
  task wait_rdy(input integer lim);
    ok = 1'b0;
    for (n = 0; n < lim && !ok; n++) begin
      @(posedge clk);
      ok = rdy_n === 1'b0;
    end
  endtask
  task pulse;
    wait_rdy(600);
    for (n = 0; n < 400 && rdy_n === 1'b0; n++) @(posedge clk);
    chk(n, 200);
  endtask
  // fresh words; temperature high stays above low
  task roll;
    for (i = 0; i < 10; i++) val[i] = $random(seed) & 32'h3FF;
    val[8] = val[8] + val[9];
  endtask
  // model: a finished group lands in its own data words
  task upd(input logic [7:0] c);
    for (i = c[3:0]; i <= c[7:4]; i++)
      exp_d[i] = (i == 8) ? val[8] - val[9] : val[i];
  endtask
  task rdchk(input logic [7:0] c);
    for (i = c[3:0]; i <= c[7:4]; i++) begin
      bus(1'b0, 8'h40 + 8'(4 * i), 32'h0);
      chk(rd, exp_d[i]);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    give_verdict;
  end
  initial begin
    for (i = 0; i < 9; i++) exp_d[i] = 0;
    roll;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdchk(8'h80);
    chk(rdy_n, 1'b1);
    // direct scans: split group, full range, temperature alone
    bus(1'b1, 8'h04, 32'h0);
    foreach (grp[g]) begin
      roll;
      bus(1'b1, 8'h00, {24'h0, grp[g]});
      wait_rdy(1500);
      chk(ok, 1'b1);
      bus(1'b0, 8'h08, 32'h0);
      chk(rd[0], 1'b1);
      upd(grp[g]);
      rdchk(grp[g]);
      chk(rdy_n, 1'b1);
    end
    $display("direct done");
    // auto rescan, then a direct write restarts and stops it
    roll;
    bus(1'b1, 8'h00, 32'h110);
    pulse;
    bus(1'b0, 8'h08, 32'h0);
    chk(rd[0], 1'b0);
    upd(8'h10);
    rdchk(8'h10);
    pulse;
    roll;
    bus(1'b1, 8'h00, 32'h33);
    wait_rdy(300);
    bus(1'b0, 8'h08, 32'h0);
    chk(rd[0], 1'b1);
    upd(8'h33);
    rdchk(8'h33);
    wait_rdy(150);
    chk(ok, 1'b0);
    $display("auto done");
    // external strobe; a control write alone starts nothing
    bus(1'b1, 8'h04, 32'h1);
    roll;
    bus(1'b1, 8'h00, 32'h166);
    wait_rdy(150);
    chk(ok, 1'b0);
    conv <= 1'b1;
    repeat (3) @(posedge clk);
    conv <= 1'b0;
    wait_rdy(300);
    chk(ok, 1'b1);
    bus(1'b0, 8'h08, 32'h0);
    chk(rd[0], 1'b1);
    upd(8'h66);
    rdchk(8'h66);
    wait_rdy(150);
    chk(ok, 1'b0);
    $display("external done");
    // an open frame on word five holds back its update
    bus(1'b1, 8'h04, 32'h0);
    bus(1'b1, 8'h80, 32'h5);
    hold <= 1'b1;
    repeat (20) @(posedge clk);
    roll;
    bus(1'b1, 8'h00, 32'h55);
    wait_rdy(200);
    chk(ok, 1'b0);
    bus(1'b0, 8'h54, 32'h0);
    chk(rd, exp_d[5]);
    hold <= 1'b0;
    wait_rdy(50);
    chk(ok, 1'b1);
    upd(8'h55);
    rdchk(8'h55);
    bus(1'b0, 8'hC0, 32'h0);
    chk(rd, 32'h0);
    $display("serial done");
    give_verdict;
  end
endmodule
bind adcsq_top adcsq_sva u_sva (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mux_channel(mux_channel),
  .temp_high_current(temp_high_current),
  .result_ready_pin_n(result_ready_pin_n));
`default_nettype wire
